//--- spm_cfg.svh
// Constants for the serial master: offsets, field positions, reset values
// What this block does
// R1: Full-duplex: receive while transmitting, same clocks
// R2: One done flag per byte, sent and received
// R3: Received bits enter shift register MSB first
// R4: Full byte copied to receive buffer, data read
// R5: Select mode 01 is multi-master, reset default
// R6: Low select in multi-master while enable bit set drops enables, sets fault
// R7: Fault flag raises interrupt when enabled
// R8: Software must re-enable after a fault
// R9: Select mode 00: three-wire, select unused
// R10: Upper select bit set: select driven out
// R11: Four-wire select level follows lower mode bit
// R12: Serial clock is clock over 2*(divisor+1)
// R13: Data write loads and starts a transfer
// R14: Clock only during transfer, transmit MSB first
// R15: Divisor acts only in master operation
`ifndef SPM_CFG_SVH
`define SPM_CFG_SVH
`define SPM_OFS_CTRL      8'hA1
`define SPM_OFS_DIV       8'hA2
`define SPM_OFS_DATA      8'hA3
`define SPM_BIT_EN        0
`define SPM_BIT_IE        1
`define SPM_BIT_SEL_LO    2
`define SPM_BIT_SEL_HI    3
`define SPM_BIT_BUSY      4
`define SPM_BIT_FAULT     5
`define SPM_BIT_MASTER    6
`define SPM_BIT_DONE      7
`define SPM_CTRL_RESET    8'h04
`define SPM_DIV_RESET     8'h00
`define SPM_DATA_RESET    8'h00
`define SPM_LAST_BIT      3'h7
`endif

//--- spm_pkg.sv
// Types shared by the serial master modules
`default_nettype none
package spm_pkg;
	typedef enum logic [1:0]
	{
		SPM_IDLE  = 2'b00,
		SPM_SHIFT = 2'b01,
		SPM_DONE  = 2'b11
	} spm_state_t;
	typedef enum logic [1:0]
	{
		SPM_THREE_WIRE = 2'b00,
		SPM_MULTI      = 2'b01,
		SPM_FOUR_LO    = 2'b10,
		SPM_FOUR_HI    = 2'b11
	} spm_sel_mode_t;
endpackage : spm_pkg
`default_nettype wire

//--- spm_rate_if.sv
// Interface between the shift engine and its rate divider
`default_nettype none
interface spm_rate_if;
	logic       run;
	logic [7:0] divisor;
	logic       tick;
	modport engine (output run, output divisor, input tick);
	modport divider (input run, input divisor, output tick);
endinterface : spm_rate_if
`default_nettype wire

//--- spm_rate.sv
// Rate divider: one tick per half period of the serial clock
`default_nettype none
module spm_rate
(
	input  wire logic   clk,
	input  wire logic   reset,
	spm_rate_if.divider rate
);
	logic [7:0] count;
	logic [7:0] next_count;

	always_comb
	begin
		// Held at zero while idle so every transfer starts on a full half period
		if (!rate.run)
			next_count = 8'h00;
		else if (count == rate.divisor)
			next_count = 8'h00;
		else
			next_count = count + 8'h01;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			count <= 8'h00;
		else
			count <= next_count;
	end

	assign rate.tick = rate.run && (count == rate.divisor); // R12
endmodule : spm_rate
`default_nettype wire

//--- spm_top.sv
// Serial master with select modes, rate divider and register port
`include "spm_cfg.svh"
`default_nettype none
module spm_top
(
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	output logic            irq,
	output logic            sck,
	output logic            sck_oe,
	output logic            mosi,
	input  wire logic       miso,
	input  wire logic       select_in,
	output logic            select_out,
	output logic            select_oe
);
	function automatic logic hit(input logic [7:0] addr,
		input logic [7:0] ofs);
		hit = (addr == ofs);
	endfunction : hit

	spm_rate_if rate ();

	spm_rate u_rate
	(
		.clk   (clk),
		.reset (reset),
		.rate  (rate)
	);

	// Synchronisers for pins
	logic miso_m;
	logic miso_s;
	logic sel_m;
	logic sel_s;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			miso_m <= 1'b0;
			miso_s <= 1'b0;
			sel_m  <= 1'b1;
			sel_s  <= 1'b1;
		end
		else
		begin
			miso_m <= miso;
			miso_s <= miso_m;
			sel_m  <= select_in;
			sel_s  <= sel_m;
		end
	end

	// Register state
	logic [7:0] ctrl;
	logic [7:0] divisor;
	logic [7:0] rx_buf;
	logic [7:0] next_ctrl;
	logic [7:0] next_divisor;
	logic [7:0] next_rx_buf;

	// Engine state
	spm_pkg::spm_state_t state;
	spm_pkg::spm_state_t next_state;
	logic [7:0]          tx_sh;
	logic [7:0]          rx_sh;
	logic [2:0]          bit_cnt;
	logic                sck_q;
	logic [7:0]          next_tx_sh;
	logic [7:0]          next_rx_sh;
	logic [2:0]          next_bit_cnt;
	logic                next_sck_q;
	logic [1:0]          smp_d;
	logic [1:0]          next_smp_d;

	spm_pkg::spm_sel_mode_t sel_mode;
	logic                   enabled;
	logic                   fault;
	logic                   start;
	logic                   byte_done;
	logic                   wr_ctrl;

	assign sel_mode = spm_pkg::spm_sel_mode_t'({ctrl[`SPM_BIT_SEL_HI],
		ctrl[`SPM_BIT_SEL_LO]});
	assign enabled  = ctrl[`SPM_BIT_EN] && ctrl[`SPM_BIT_MASTER];
	// Low select from a competing master
	assign fault    = (sel_mode == spm_pkg::SPM_MULTI) && !sel_s
		&& ctrl[`SPM_BIT_EN]; // R5 R6
	// Writes during a byte are dropped; no collision flag is kept
	assign start    = reg_wr && hit(reg_addr, `SPM_OFS_DATA) && enabled
		&& (state == spm_pkg::SPM_IDLE) && !fault; // R13
	assign byte_done = (state == spm_pkg::SPM_DONE);
	assign wr_ctrl  = reg_wr && hit(reg_addr, `SPM_OFS_CTRL);

	always_comb
	begin
		next_ctrl    = ctrl;
		next_divisor = divisor;
		next_rx_buf  = rx_buf;
		if (wr_ctrl)
			next_ctrl = reg_wdata;
		next_ctrl[`SPM_BIT_BUSY] = (next_state != spm_pkg::SPM_IDLE);
		if (byte_done)
		begin
			// Last bit may land in the done cycle at divisor 0
			next_rx_buf              = next_rx_sh; // R4
			next_ctrl[`SPM_BIT_DONE] = 1'b1; // R2
		end
		// Hardware never sets the enables back; software must
		if (fault)
		begin
			next_ctrl[`SPM_BIT_MASTER] = 1'b0; // R6 R8
			next_ctrl[`SPM_BIT_EN]     = 1'b0; // R6
			next_ctrl[`SPM_BIT_FAULT]  = 1'b1; // R6
		end
		if (reg_wr && hit(reg_addr, `SPM_OFS_DIV))
			next_divisor = reg_wdata;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ctrl    <= `SPM_CTRL_RESET; // R5
			divisor <= `SPM_DIV_RESET;
			rx_buf  <= `SPM_DATA_RESET;
		end
		else
		begin
			ctrl    <= next_ctrl;
			divisor <= next_divisor;
			rx_buf  <= next_rx_buf;
		end
	end

	// Shift engine, clock idle low, sample on rising, change on falling
	assign rate.run     = (state == spm_pkg::SPM_SHIFT);
	assign rate.divisor = divisor; // R12 R15

	always_comb
	begin
		next_state   = state;
		next_tx_sh   = tx_sh;
		next_rx_sh   = rx_sh;
		next_bit_cnt = bit_cnt;
		next_sck_q   = sck_q;
		next_smp_d   = {smp_d[0], 1'b0};
		case (state)
			spm_pkg::SPM_IDLE:
			begin
				next_sck_q = 1'b0;
				if (start)
				begin
					next_tx_sh   = reg_wdata;
					next_bit_cnt = 3'h0;
					next_state   = spm_pkg::SPM_SHIFT;
				end
			end
			spm_pkg::SPM_SHIFT:
			begin
				if (fault || !enabled)
				begin
					next_sck_q = 1'b0;
					next_state = spm_pkg::SPM_IDLE;
				end
				else if (rate.tick && !sck_q)
				begin
					next_sck_q = 1'b1;
					// Pin is two flops late; sample once they catch up
					next_smp_d[0] = 1'b1; // R1 R3
				end
				else if (rate.tick)
				begin
					next_sck_q = 1'b0;
					next_tx_sh = {tx_sh[6:0], 1'b0}; // R14
					next_bit_cnt = bit_cnt + 3'h1;
					if (bit_cnt == `SPM_LAST_BIT)
						next_state = spm_pkg::SPM_DONE;
				end
			end
			spm_pkg::SPM_DONE:
			begin
				next_sck_q = 1'b0;
				next_state = spm_pkg::SPM_IDLE;
			end
			default:
			begin
				next_sck_q = 1'b0;
				next_state = spm_pkg::SPM_IDLE;
			end
		endcase
		if (smp_d[1])
			next_rx_sh = {rx_sh[6:0], miso_s}; // R1 R3
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state   <= spm_pkg::SPM_IDLE;
			tx_sh   <= 8'h00;
			rx_sh   <= 8'h00;
			bit_cnt <= 3'h0;
			sck_q   <= 1'b0;
			smp_d   <= 2'h0;
		end
		else
		begin
			state   <= next_state;
			tx_sh   <= next_tx_sh;
			rx_sh   <= next_rx_sh;
			bit_cnt <= next_bit_cnt;
			sck_q   <= next_sck_q;
			smp_d   <= next_smp_d;
		end
	end

	// Read port
	logic [7:0] next_rdata;

	always_comb
	begin
		next_rdata = reg_rdata;
		if (reg_rd)
		begin
			if (hit(reg_addr, `SPM_OFS_CTRL))
				next_rdata = ctrl;
			else if (hit(reg_addr, `SPM_OFS_DIV))
				next_rdata = divisor;
			else if (hit(reg_addr, `SPM_OFS_DATA))
				next_rdata = rx_buf; // R4
			else
				next_rdata = 8'h00;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= next_rdata;
	end

	// Pins
	assign sck    = sck_q; // R14
	assign sck_oe = enabled; // R15
	assign mosi   = tx_sh[7]; // R14
	// Select pin: output only in four-wire mode
	assign select_oe  = ctrl[`SPM_BIT_SEL_HI]; // R9 R10
	assign select_out = ctrl[`SPM_BIT_SEL_LO]; // R11
	assign irq = ctrl[`SPM_BIT_IE]
		&& (ctrl[`SPM_BIT_FAULT] || ctrl[`SPM_BIT_DONE]); // R7
endmodule : spm_top
`default_nettype wire

//--- spm_monitor.sv
// Port checker for the serial master
`default_nettype none
module spm_monitor
(
	input wire logic	clk,
	input wire logic	reset,
	input wire logic [7:0]	reg_addr,
	input wire logic	reg_wr,
	input wire logic	reg_rd,
	input wire logic [7:0]	reg_wdata,
	input wire logic [7:0]	reg_rdata,
	input wire logic	sck,
	input wire logic	sck_oe,
	input wire logic	mosi,
	input wire logic	select_in,
	input wire logic	select_out,
	input wire logic	select_oe
);
	logic [1:0]	mode_q;
	logic [7:0]	div_q;
	logic [8:0]	hcnt;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Shadows of the written fields, no hardware writes them
	always_ff @(posedge clk)
	begin
		if (reset)
			{mode_q, div_q} <= 10'h100;
		else if (reg_wr && reg_addr == 8'hA1)
			mode_q <= reg_wdata[3:2];
		else if (reg_wr && reg_addr == 8'hA2)
			div_q <= reg_wdata;
	end
	always_ff @(posedge clk)
		hcnt <= $changed(sck) ? 9'h000 : hcnt + 9'h001;
	property p_idle; !sck_oe |-> !sck; endproperty
	a_idle: assert property (p_idle) else $error("sck off");
	property p_oe; select_oe == mode_q[1]; endproperty
	a_oe: assert property (p_oe) else $error("select oe");
	property p_so; select_oe |-> select_out == mode_q[0]; endproperty
	a_so: assert property (p_so) else $error("select level");
	property p_half; $fell(sck) && sck_oe |-> hcnt == {1'b0, div_q};
	endproperty
	a_half: assert property (p_half) else $error("half period");
	property p_flt; !select_in && sck_oe && mode_q == 2'h1
		|-> ##[1:3] !sck_oe; endproperty
	a_flt: assert property (p_flt) else $error("no fault");
	property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
	a_hold: assert property (p_hold) else $error("read data");
	property p_mosi; sck |-> $stable(mosi); endproperty
	a_mosi: assert property (p_mosi) else $error("mosi moved");
	property p_mode; reg_rd && reg_addr == 8'hA1
		|=> reg_rdata[3:2] == $past(mode_q); endproperty
	a_mode: assert property (p_mode) else $error("mode bits");
endmodule : spm_monitor
bind spm_top spm_monitor i_mon (.clk, .reset, .reg_addr, .reg_wr,
	.reg_rd, .reg_wdata, .reg_rdata, .sck, .sck_oe, .mosi,
	.select_in, .select_out, .select_oe);
`default_nettype wire

//--- spm_slave_model.sv
// Serial slave model, mode 0
`default_nettype none
module spm_slave_model
(
	input wire logic	load,
	input wire logic	sck,
	input wire logic	mosi,
	input wire logic [7:0]	tx,
	output logic		miso,
	output logic [7:0]	rx
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]	sh;
	logic [2:0]	k;
	assign miso = sh[7];
	always @(posedge sck)
		rx <= {rx[6:0], mosi};
	// Filler bits toggle so a stale line never looks right
	always @(negedge sck or posedge load)
	begin
		if (load || k == 3'h7)
			{sh, k} <= {tx, 3'h0};
		else
			{sh, k} <= {sh[6:0], !sh[0], k + 3'h1};
	end
endmodule : spm_slave_model
`default_nettype wire

//--- spm_top_tb.sv
// Bench for the serial master
`default_nettype none
module spm_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// Rows: divisor, control, sent byte, slave byte
	logic [31:0] rows [4] = '{32'h0141A53C, 32'h0445817E, 32'hFF4B5AC3,
		32'h004F9669};
	logic [31:0] r;
	logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, select_in = 1, ld = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdat, reg_rdata, sl_rx;
	logic irq, sck, sck_oe, mosi, miso, select_out, select_oe;
	int miscompares = 0, num_checks = 0;
	spm_top i_dut (.clk, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
		.reg_rdata, .irq, .sck, .sck_oe, .mosi, .miso, .select_in,
		.select_out, .select_oe);
	spm_slave_model i_sl (.load(ld), .sck, .mosi, .tx(r[7:0]), .miso,
		.rx(sl_rx));
	initial forever #2.5 clk = ~clk;
	task automatic stop_test;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test
	task automatic chk(input string n, input logic [7:0] e, g);
		num_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [7:0] a, d);
		@(negedge clk);
		{reg_addr, reg_wdata, reg_wr, reg_rd} = {a, d, w, !w};
		@(negedge clk);
		{reg_wr, reg_rd} = 2'h0;
		rdat = reg_rdata;
	endtask : acc
	initial
	begin
		repeat (12) @(negedge clk);
		reset = 0;
		foreach (rows[i])
		begin
			r = rows[i];
			// Let the new slave byte settle before loading it
			#1 ld = 1;
			#1 ld = 0;
			acc(1, 8'hA2, r[31:24]);
			acc(1, 8'hA1, r[23:16]);
			acc(1, 8'hA3, r[15:8]);
			rdat = 8'h00;
			for (int n = 0; n < 3000 && rdat[7] !== 1'b1; n++)
				acc(0, 8'hA1, 8'h00);
			chk("ctrl", r[23:16] | 8'h80, rdat);
			if (rdat[7] !== 1'b1)
				stop_test();
			chk("irq", {7'h00, r[17]}, {7'h00, irq});
			acc(0, 8'hA3, 8'h00);
			chk("rx", r[7:0], rdat);
			chk("tx", r[15:8], sl_rx);
			acc(1, 8'hA1, 8'h00);
		end
		acc(1, 8'hA1, 8'h47);
		select_in = 0;
		repeat (5) @(negedge clk);
		acc(0, 8'hA1, 8'h00);
		chk("fault", 8'h26, rdat);
		chk("fault irq", 8'h01, {7'h00, irq});
		select_in = 1;
		repeat (3) @(negedge clk);
		acc(1, 8'hA1, 8'h47);
		acc(0, 8'hA1, 8'h00);
		chk("reenable", 8'h47, rdat);
		acc(1, 8'hA1, 8'h41);
		select_in = 0;
		repeat (5) @(negedge clk);
		acc(0, 8'hA1, 8'h00);
		chk("three wire", 8'h41, rdat);
		select_in = 1;
		reset = 1;
		repeat (2) @(negedge clk);
		reset = 0;
		for (int k = 0; k < 4; k++)
		begin
			acc(0, 8'hA0 + 8'((k + 1) % 4), 8'h00);
			chk("reset", (k == 0) ? 8'h04 : 8'h00, rdat);
		end
		stop_test();
	end
endmodule : spm_top_tb
`default_nettype wire
